// ---- design/rtcv_defines.vh ----
// register map, field layout and timing constants of the counter/calendar block
// Summary of operation
// - enable-clear register at 0x08 clears enables; set register shows the same enables.
// - enable-clear layout applies only when operating mode select equals 1.
// - writing 1 to bit 15 clears and disables the overflow interrupt.
// - writing 1 to bit 14 clears and disables the tamper interrupt.
// - bits 11:8 clear compare interrupt enables, channels 3 to 0.
// - bits 7:0 clear periodic interrupt enables, channels 7 to 0.
// - writing 0 leaves an enable alone; reads return 1 enabled, 0 disabled.
// - in calendar mode (select 2) date and time read as one word at 0x18.
// - bits 31:26 hold a six-bit year offset from a software reference year.
// - a year is leap exactly when year bits 1:0 are both zero.
// - bits 25:22 hold month, 1 for January through 12 for December.
// - bits 21:17 hold day, 1 up to 28, 29, 30 or 31.
// - bits 16:12 hold hour; format select 0 gives 24-hour values 0-23.
// - format select 1 gives hour 1-12 in low bits, top bit PM.
// - bits 11:6 hold minute, 0 to 59.
`ifndef RTCV_DEFINES_VH
`define RTCV_DEFINES_VH
`define RTCV_OFF_CTRL 12'h000
`define RTCV_OFF_ENCLR 12'h008
`define RTCV_OFF_ENSET 12'h00C
`define RTCV_OFF_IRQ_STAT 12'h010
`define RTCV_OFF_IRQ_MASK 12'h014
`define RTCV_OFF_CLOCK 12'h018
`define RTCV_OFF_COUNT 12'h01C
`define RTCV_OFF_EVENT 12'h020
`define RTCV_MODE_CNT16 2'h1
`define RTCV_MODE_CAL 2'h2
`define RTCV_CTRL_MODE_LO 0
`define RTCV_CTRL_MODE_HI 1
`define RTCV_CTRL_FMT 2
`define RTCV_CTRL_EN 3
`define RTCV_EN_OVF 15
`define RTCV_EN_TAMP 14
`define RTCV_EN_CMP_LO 8
`define RTCV_EN_CMP_HI 11
`define RTCV_EN_PER_LO 0
`define RTCV_EN_PER_HI 7
`define RTCV_EN_MASK 16'hCFFF
`define RTCV_YEAR_LO 26
`define RTCV_MON_LO 22
`define RTCV_DAY_LO 17
`define RTCV_HOUR_LO 12
`define RTCV_MIN_LO 6
`define RTCV_SEC_LO 0
`define RTCV_SEC_MAX 6'h3B
`define RTCV_MIN_MAX 6'h3B
`define RTCV_HR_MAX 5'h17
`define RTCV_MON_MAX 4'hC
`define RTCV_YR_MAX 6'h3F
`define RTCV_CLOCK_RST 32'h00000000
`define RTCV_ENABLE_RST 16'h0000
`define RTCV_CLK_HZ 200000000
`define RTCV_TICK_S 1
`define RTCV_TICK_CYC (`RTCV_CLK_HZ * `RTCV_TICK_S)
`define RTCV_ST_SEC 0
`define RTCV_ST_MIN 1
`define RTCV_ST_HOUR 2
`define RTCV_ST_DAY 3
`define RTCV_ST_MON 4
`define RTCV_ST_YEAR 5
`define RTCV_ST_OVF 6
`endif

// ---- design/rtcv_top.v ----
// counter/calendar block: enable registers, calendar time word, apb slave, interrupt
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rtcv_defines.vh"
module rtcv_top #(
	parameter TICK_CYCLES = `RTCV_TICK_CYC
) (
	input wire clk, // 200 MHz
	input wire rst_n, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	input wire [3:0] pstrb, // apb byte strobes
	output wire pready, // apb ready
	output reg [31:0] prdata, // apb read data
	output wire pslverr, // apb error
	input wire tamper_in, // tamper pin, asynchronous
	output wire irq, // level interrupt
	output wire [15:0] irq_enables // enable bits seen by the interrupt logic
);
	// overview of the block as software sees it
	// - one clock; the one-second rate is a one-cycle tick from a divider
	// - reset comes in asynchronously and leaves through two flops
	// - every bus transfer ends with zero wait states, so ready is tied high
	// - read data is captured at the setup edge and stands through the access phase
	// - an unmapped address answers with an error, reads zero, and writes nothing
	// - the enable pair at the clear and set offsets only answers in counter mode
	// - the clear offset removes enables, the set offset adds them, zeros do nothing
	// - both offsets read back the same enable bits, so a change shows in both
	// - enable bits 13:12 are not built and always read zero
	// - the calendar word only answers in calendar mode
	// - the calendar is kept in 24-hour form; 12-hour form is made on the way in and out
	// - leap years are those whose year offset has its two low bits clear
	// - fields step only on a tick while the run bit is set
	// - each field rolls into the next one above when it passes its last value
	// - the year offset wraps from its top value back to zero
	// - events set sticky status bits; writing one clears a bit
	// - an event in the same cycle as its clear wins, so no event is lost
	// - calendar roll events count only on a real tick, not while a field sits at its top
	// - one level interrupt, high while any status bit is set and masked in
	// limitation: calendar writes with out-of-range fields are taken as written,
	// and the roll logic then runs on from whatever was written
	// trade-off: a calendar read shows the value of its setup edge, so a tick in
	// the access cycle shows on the next read and never as a torn word
	// hazard: the tamper pin is asynchronous and passes two flops before any use
	// hazard: the internal reset is a flop output, so it is glitch free at release
	reg rst_s1_q, rst_s2_q;
	wire rst_int_n = rst_s2_q;
	// reset release through two flops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// days in month, leap when year[1:0] zero
	function [4:0] days_in_month;
		input [3:0] mon;
		input [5:0] yr;
		begin
			case (mon)
				4'h1: days_in_month = 5'h1F;
				4'h2: days_in_month = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
				4'h3: days_in_month = 5'h1F;
				4'h4: days_in_month = 5'h1E;
				4'h5: days_in_month = 5'h1F;
				4'h6: days_in_month = 5'h1E;
				4'h7: days_in_month = 5'h1F;
				4'h8: days_in_month = 5'h1F;
				4'h9: days_in_month = 5'h1E;
				4'hA: days_in_month = 5'h1F;
				4'hB: days_in_month = 5'h1E;
				4'hC: days_in_month = 5'h1F;
				// out-of-range months are software's fault; treat them as long months
				default: days_in_month = 5'h1F;
			endcase
		end
	endfunction

	// convert 24-hour value to 12-hour form, pm in bit 4
	function [4:0] to_h12;
		input [4:0] h;
		reg [4:0] t;
		begin
			t = (h >= 5'h0C) ? h - 5'h0C : h;
			to_h12 = {(h >= 5'h0C), (t == 5'h00) ? 4'hC : t[3:0]};
		end
	endfunction

	// convert 12-hour form back to 24-hour value
	function [4:0] from_h12;
		input [4:0] h;
		reg [4:0] t;
		begin
			t = (h[3:0] == 4'hC) ? 5'h00 : {1'b0, h[3:0]};
			from_h12 = h[4] ? t + 5'h0C : t;
		end
	endfunction

	// tamper pin synchroniser; only the second flop is read by logic
	reg tmp_s1_q, tmp_s2_q, tmp_s3_q;
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			tmp_s1_q <= 1'b0;
			tmp_s2_q <= 1'b0;
		end else begin
			tmp_s1_q <= tamper_in;
			tmp_s2_q <= tmp_s1_q;
		end
	end
	// edge flop resets low like the idle pin, so no false edge after reset
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			tmp_s3_q <= 1'b0;
		else
			tmp_s3_q <= tmp_s2_q;
	end
	wire tamper_evt = tmp_s2_q & ~tmp_s3_q;

	// bus decode; the slave always answers in the access cycle
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] wd = pwdata & wmask;
	// address map decode, shared by the error flag and the read capture
	function is_mapped;
		input [11:0] a;
		begin
			case (a)
				`RTCV_OFF_CTRL, `RTCV_OFF_ENCLR, `RTCV_OFF_ENSET, `RTCV_OFF_IRQ_STAT,
				`RTCV_OFF_IRQ_MASK, `RTCV_OFF_CLOCK, `RTCV_OFF_COUNT,
				`RTCV_OFF_EVENT: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction
	wire hit = is_mapped(paddr);
	// setup phase: address and direction valid, access not yet started
	wire setup_ph = psel & ~penable;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	// write strobes of the plain registers
	wire we_ctrl = wr && (paddr == `RTCV_OFF_CTRL);
	wire we_count = wr && (paddr == `RTCV_OFF_COUNT);
	wire we_stat = wr && (paddr == `RTCV_OFF_IRQ_STAT);
	wire we_mask = wr && (paddr == `RTCV_OFF_IRQ_MASK);

	reg [3:0] ctrl_q;
	reg [15:0] en_q;
	reg [15:0] cnt_q;
	reg [15:0] cmp_q;
	reg [31:0] tick_q;
	reg [31:0] clock_q;
	reg [6:0] stat_q;
	reg [6:0] mask_q;
	wire [1:0] mode = ctrl_q[`RTCV_CTRL_MODE_HI:`RTCV_CTRL_MODE_LO];
	wire fmt12 = ctrl_q[`RTCV_CTRL_FMT];
	wire cnt16 = (mode == `RTCV_MODE_CNT16);
	wire calm = (mode == `RTCV_MODE_CAL);
	wire running = ctrl_q[`RTCV_CTRL_EN];

	// control register
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			ctrl_q <= 4'h0;
		else if (we_ctrl)
			ctrl_q <= wd[3:0];
	end

	// one-second tick divider
	wire tick = running && (tick_q == TICK_CYCLES - 1);
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			tick_q <= 32'h00000000;
		else if (!running || tick)
			tick_q <= 32'h00000000;
		else
			tick_q <= tick_q + 32'h00000001;
	end

	// enable bits: set register ors in ones, clear register removes them, zeros ignored
	wire en_set_wr = wr && cnt16 && paddr == `RTCV_OFF_ENSET;
	wire en_clr_wr = wr && cnt16 && paddr == `RTCV_OFF_ENCLR;
	// which enable bits exist and what they reset to; 13:12 are not built
	localparam [15:0] EN_IMPL = `RTCV_EN_MASK;
	localparam [15:0] EN_RST = `RTCV_ENABLE_RST;
	wire [15:0] en_d;
	// one next-value slice per bit; a clear one beats a set one, a zero leaves it alone
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_en
			if (EN_IMPL[gi]) begin : g_bit
				assign en_d[gi] = (en_clr_wr && wd[gi]) ? 1'b0 :
					(en_set_wr && wd[gi]) ? 1'b1 : en_q[gi];
			end else begin : g_rsv
				// reserved bit, reads zero whatever is written
				assign en_d[gi] = 1'b0;
			end
		end
	endgenerate
	// enables used by the event logic: overflow, tamper, compare 0
	wire en_ovf = en_q[`RTCV_EN_OVF];
	wire en_tamp = en_q[`RTCV_EN_TAMP];
	wire en_cmp0 = en_q[`RTCV_EN_CMP_LO];
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			en_q <= EN_RST;
		else
			en_q <= en_d;
	end
	assign irq_enables = en_q;

	// 16-bit counter with compare 0 against the compare word written with the count
	wire cnt_ovf = cnt16 && tick && (cnt_q == 16'hFFFF);
	wire cmp_hit = cnt16 && tick && (cnt_q == cmp_q);
	// the count loads from the bus and otherwise steps once per tick in counter mode
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			cnt_q <= 16'h0000;
		else if (we_count)
			cnt_q <= wd[15:0];
		else if (cnt16 && tick)
			cnt_q <= cnt_q + 16'h0001;
	end
	// compare word shares the count's write, upper half of the same word
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			cmp_q <= 16'h0000;
		else if (we_count)
			cmp_q <= wd[31:16];
	end

	// calendar fields, held internally in 24-hour form
	wire [5:0] yr = clock_q[31:26];
	wire [3:0] mon = clock_q[25:22];
	wire [4:0] day = clock_q[21:17];
	wire [4:0] hr = clock_q[16:12];
	wire [5:0] mn = clock_q[11:6];
	wire [5:0] sc = clock_q[5:0];
	wire sec_wrap = (sc == `RTCV_SEC_MAX);
	wire min_wrap = sec_wrap && (mn == `RTCV_MIN_MAX);
	wire hr_wrap = min_wrap && (hr == `RTCV_HR_MAX);
	wire day_wrap = hr_wrap && (day == days_in_month(mon, yr));
	wire mon_wrap = day_wrap && (mon == `RTCV_MON_MAX);
	wire yr_wrap = mon_wrap && (yr == `RTCV_YR_MAX);
	// one calendar step; the wraps above only count as events on a real step
	wire cal_step = calm && tick;
	// step of one calendar field: hold, wrap to its first value, or count up
	function [5:0] step_field;
		input carry_in;
		input [5:0] cur;
		input [5:0] last;
		input [5:0] first;
		begin
			if (!carry_in)
				step_field = cur;
			else if (cur == last)
				step_field = first;
			else
				step_field = cur + 6'h01;
		end
	endfunction
	// next value of each field; a field moves only when every field below wraps
	wire [5:0] sec_d = step_field(1'b1, sc, `RTCV_SEC_MAX, 6'h00);
	wire [5:0] min_d = step_field(sec_wrap, mn, `RTCV_MIN_MAX, 6'h00);
	wire [5:0] hr_s = step_field(min_wrap, {1'b0, hr}, {1'b0, `RTCV_HR_MAX}, 6'h00);
	wire [4:0] hr_d = hr_s[4:0];
	wire [5:0] day_s = step_field(hr_wrap, {1'b0, day}, {1'b0, days_in_month(mon, yr)}, 6'h01);
	wire [4:0] day_d = day_s[4:0];
	wire [5:0] mon_s = step_field(day_wrap, {2'h0, mon}, {2'h0, `RTCV_MON_MAX}, 6'h01);
	wire [3:0] mon_d = mon_s[3:0];
	// the year wraps from its top value to zero; software owns the reference year
	wire [5:0] yr_d = step_field(mon_wrap, yr, `RTCV_YR_MAX, 6'h00);
	wire [31:0] tick_val = {yr_d, mon_d, day_d, hr_d, min_d, sec_d};
	// write data in 12-hour form is converted so the counter stays in one form
	wire [4:0] wr_hr = fmt12 ? from_h12(wd[16:12]) : wd[16:12];
	wire [31:0] wr_val = {wd[31:17], wr_hr, wd[11:0]};
	// a bus write wins over a tick in the same cycle, so software reads what it wrote
	wire cal_we = wr && calm && (paddr == `RTCV_OFF_CLOCK);
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			clock_q <= `RTCV_CLOCK_RST;
		else if (cal_we)
			clock_q <= wr_val;
		else if (cal_step)
			clock_q <= tick_val;
	end
	wire [4:0] rd_hr = fmt12 ? to_h12(hr) : hr;
	wire [31:0] clock_rd = {clock_q[31:17], rd_hr, clock_q[11:0]};

	// sticky events; a new event wins over a write-one clear in the same cycle
	wire [6:0] evt = {yr_wrap & cal_step, mon_wrap & cal_step, day_wrap & cal_step,
		hr_wrap & cal_step, cmp_hit & en_cmp0, tamper_evt & en_tamp, cnt_ovf & en_ovf};
	// next status per bit: a written one clears, a new event in the same cycle wins
	wire [6:0] stat_d;
	genvar si;
	generate
		for (si = 0; si < 7; si = si + 1) begin : g_stat
			assign stat_d[si] = evt[si] | (stat_q[si] & ~(we_stat & wd[si]));
		end
	endgenerate
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			stat_q <= 7'h00;
		else
			stat_q <= stat_d;
	end
	// mask register, same layout as the status bits
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			mask_q <= 7'h00;
		else if (we_mask)
			mask_q <= wd[6:0];
	end
	assign irq = |(stat_q & mask_q);

	// read selection; clear and set addresses read the same enables
	reg [31:0] rd_mux;
	always @* begin
		case (paddr)
			`RTCV_OFF_CTRL: rd_mux = {28'h0000000, ctrl_q};
			`RTCV_OFF_ENCLR: rd_mux = cnt16 ? {16'h0000, en_q} : 32'h00000000;
			`RTCV_OFF_ENSET: rd_mux = cnt16 ? {16'h0000, en_q} : 32'h00000000;
			`RTCV_OFF_IRQ_STAT: rd_mux = {25'h0000000, stat_q};
			`RTCV_OFF_IRQ_MASK: rd_mux = {25'h0000000, mask_q};
			`RTCV_OFF_CLOCK: rd_mux = calm ? clock_rd : 32'h00000000;
			`RTCV_OFF_COUNT: rd_mux = {cmp_q, cnt_q};
			default: rd_mux = 32'h00000000;
		endcase
	end
	// read data flop, loaded in the setup phase so it stands through the access phase
	always @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n)
			prdata <= 32'h00000000;
		else if (setup_ph)
			prdata <= is_mapped(paddr) ? rd_mux : 32'h00000000;
	end
endmodule

// ---- dv/rtcv_sva.sv ----
// port checker for the enable registers, bus ready and the unmapped-address error
`timescale 1ns/1ps
module rtcv_sva (
	input wire clk, // clock
	input wire rst_n, // reset
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // write
	input wire [11:0] paddr, // address
	input wire [31:0] pwdata, // wdata
	input wire [3:0] pstrb, // strobes
	input wire pready, // ready
	input wire [31:0] prdata, // rdata
	input wire pslverr, // error
	input wire irq, // interrupt
	input wire [15:0] irq_enables // enables
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	reg [1:0] mode_q;
	wire acc = psel && penable;
	wire wr = acc && pwrite && pstrb == 4'hF;
	wire m1 = mode_q == 2'h1;
	wire rd = acc && !pwrite && m1;
	wire [15:0] wd = pwdata[15:0];
	wire enw = acc && pwrite && (paddr == 12'h008 || paddr == 12'h00C);
	// mode shadow from bus writes, so no internal probe is needed
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mode_q <= 2'h0;
		else if (wr && paddr == 12'h000)
			mode_q <= pwdata[1:0];
	end
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_unmap; acc && paddr > 12'h020 |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no error");
	property p_clr; wr && m1 && paddr == 12'h008 |=> (irq_enables & $past(wd)) == 16'h0000;
	endproperty
	a_clr: assert property (p_clr) else $error("enable kept");
	property p_keep; wr && m1 && paddr == 12'h008 |=>
		(irq_enables & ~$past(wd)) == ($past(irq_enables) & ~$past(wd)); endproperty
	a_keep: assert property (p_keep) else $error("enable lost");
	property p_set; wr && m1 && paddr == 12'h00C |=>
		irq_enables == (($past(irq_enables) | $past(wd)) & 16'hCFFF); endproperty
	a_set: assert property (p_set) else $error("set wrong");
	property p_rdclr; rd && paddr == 12'h008 |-> prdata == {16'h0000, irq_enables};
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("clear read");
	property p_rdset; rd && paddr == 12'h00C |-> prdata == {16'h0000, irq_enables};
	endproperty
	a_rdset: assert property (p_rdset) else $error("set read");
	property p_mode; wr && !m1 && paddr == 12'h008 |=> $stable(irq_enables); endproperty
	a_mode: assert property (p_mode) else $error("clear in mode");
	property p_hold; !enw |=> $stable(irq_enables); endproperty
	a_hold: assert property (p_hold) else $error("enable moved");
	c_clr: cover property (wr && m1 && paddr == 12'h008);
	c_err: cover property (acc && pslverr);
	c_irq: cover property ($rose(irq));
endmodule
bind rtcv_top rtcv_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .irq(irq), .irq_enables(irq_enables));

// ---- dv/tb_top.sv ----
// self-checking bench for the enable and calendar registers
`timescale 1ns/1ps
module tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg tamper_in = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] pstrb = 4'hF;
	wire pready, pslverr, irq;
	wire [31:0] prdata;
	wire [15:0] irq_enables;
	reg [31:0] rv, c;
	reg [15:0] e;
	reg ev;
	integer error_cnt = 0;
	integer checked = 0;
	integer i;
	always #2.5 clk = ~clk;
	// short second so rollovers happen in a few cycles
	rtcv_top #(.TICK_CYCLES(16)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .tamper_in(tamper_in),
		.irq(irq), .irq_enables(irq_enables));
	function [31:0] cal(input [5:0] y, input [3:0] m, input [4:0] d, input [4:0] h,
		input [5:0] mi, input [5:0] s);
		cal = {y, m, d, h, mi, s};
	endfunction
	task cmp(input [31:0] g, input [31:0] x);
		begin
			checked = checked + 1;
			if (g !== x) begin
				error_cnt = error_cnt + 1;
				$display("mismatch at %0t: got %h expected %h", $time, g, x);
			end
		end
	endtask
	// flags are taken when the task is called and compared at the next falling edge
	task cmpb(input g, input x);
		begin
			@(negedge clk);
			cmp({31'h0, g}, {31'h0, x});
			@(posedge clk);
		end
	endtask
	task xfer(input [11:0] a, input w, input [31:0] d);
		begin
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			rv = prdata;
			ev = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask
	// polls until the first tick lands, polling faster than a tick
	task roll(input [31:0] w, input [31:0] x);
		begin
			xfer(12'h000, 1'b1, 32'h2);
			xfer(12'h018, 1'b1, w);
			xfer(12'h000, 1'b1, 32'hA);
			rv = w;
			while (rv === w)
				xfer(12'h018, 1'b0, 32'h0);
			cmp(rv, x);
		end
	endtask
	task results;
		begin
			$display("checked %0d mismatches %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#50000;
		error_cnt = error_cnt + 1;
		results;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		cmp({16'h0, irq_enables}, 32'h0);
		xfer(12'h100, 1'b0, 32'h0);
		cmp(rv, 32'h0);
		cmpb(ev, 1'b1);
		$display("reset and unmapped test done");
		xfer(12'h000, 1'b1, 32'h1);
		xfer(12'h00C, 1'b1, 32'hFFFF);
		xfer(12'h000, 1'b1, 32'h2);
		xfer(12'h008, 1'b1, 32'hFFFF);
		xfer(12'h000, 1'b1, 32'h1);
		xfer(12'h008, 1'b1, 32'h0);
		xfer(12'h008, 1'b0, 32'h0);
		cmp(rv, 32'hCFFF);
		e = 16'hCFFF;
		for (i = 0; i < 16; i = i + 1) begin
			xfer(12'h008, 1'b1, 32'h1 << i);
			e = e & ~(16'h1 << i);
			xfer(12'h00C, 1'b0, 32'h0);
			cmp(rv, {16'h0, e});
		end
		$display("enable clear test done");
		xfer(12'h00C, 1'b1, 32'h4000);
		tamper_in <= 1'b1;
		repeat (6) @(posedge clk);
		cmpb(irq, 1'b0);
		xfer(12'h014, 1'b1, 32'h2);
		cmpb(irq, 1'b1);
		xfer(12'h010, 1'b1, 32'h2);
		cmpb(irq, 1'b0);
		$display("interrupt test done");
		c = cal(6'h01, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B);
		xfer(12'h000, 1'b1, 32'h2);
		xfer(12'h018, 1'b1, c);
		xfer(12'h018, 1'b0, 32'h0);
		cmp(rv, c);
		xfer(12'h000, 1'b1, 32'h6);
		xfer(12'h018, 1'b0, 32'h0);
		cmp({27'h0, rv[16:12]}, 32'h1B);
		$display("calendar layout test done");
		roll(c, cal(6'h01, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
		roll(cal(6'h04, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B),
			cal(6'h04, 4'h2, 5'h1D, 5'h00, 6'h00, 6'h00));
		$display("rollover test done");
		results;
	end
endmodule
